// ---- core/wrs_consts.vh ----
// Offsets, field positions and reset values of the wake and reset status logic
`ifndef WRS_CONSTS_VH
`define WRS_CONSTS_VH

`define WRS_ADDR_W          12
`define WRS_OFS_FLAGS       12'h000
`define WRS_OFS_WAKE_CTRL   12'h004
`define WRS_OFS_EVT_STATUS  12'h008
`define WRS_OFS_EVT_MASK    12'h00c

`define WRS_FLAG_TIMEOUT    0
`define WRS_FLAG_PDOWN      1
`define WRS_FLAG_GIE        2

`define WRS_CTL_UTX_IE      0
`define WRS_CTL_URX_IE      1
`define WRS_CTL_UERR_IE     2
`define WRS_CTL_VD_WAKE     3
`define WRS_CTL_VD_IE       4
`define WRS_CTL_W           5
`define WRS_CTL_RESET       5'h00

`define WRS_EVT_EXT_RST     0
`define WRS_EVT_WDOG_RST    1
`define WRS_EVT_LV_RST      2
`define WRS_EVT_WAKE        3
`define WRS_EVT_VECTOR      4
`define WRS_EVT_W           5
`define WRS_EVT_RESET       5'h00
`define WRS_MASK_RESET      5'h00

`define WRS_MODE_SLEEP      2'h0
`define WRS_MODE_IDLE       2'h1
`define WRS_MODE_GREEN      2'h2
`define WRS_MODE_NORMAL     2'h3

`endif

// ---- core/wrs_sync3.v ----
// Three-stage input synchroniser with agreement filter
module wrs_sync3 #(
	parameter [0:0] IDLE_LEVEL = 1'b1
) (
	input  wire ref_clk_in,
	input  wire reset_in,
	input  wire async_in,
	output wire level_out
);
	reg s1_r;
	reg s2_r;
	reg s3_r;
	reg level_r;

	// s2 and s3 must agree before level_r takes s3
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			s1_r    <= IDLE_LEVEL;
			s2_r    <= IDLE_LEVEL;
			s3_r    <= IDLE_LEVEL;
			level_r <= IDLE_LEVEL;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_r <= s3_r;
			end
		end
	end

	assign level_out = level_r;
endmodule // wrs_sync3

// ---- core/wrs_top.v ----
// Wake-up and reset cause tracking with APB status registers
//
// Summary of operation
// RL1: Core reset on power-on, external pin pulse, watchdog time-out or low voltage.
// RL2: Outside agent drives active-low reset pin high, then low, then high.
// RL3: Power-on reset sets time-out and power-down flags to one.
// RL4: External pin reset while operating keeps both flags unchanged.
// RL5: External pin reset waking from sleep: time-out one, power-down zero.
// RL6: Watchdog reset while operating: time-out zero, power-down unchanged.
// RL7: Watchdog wake from sleep clears both flags.
// RL8: Pin-change wake from sleep: time-out one, power-down zero.
// RL9: Watchdog-clear instruction sets both flags to one.
// RL10: Sleep instruction sets time-out one, clears power-down.
// RL11: Both flags are readable by software.
// RL12: Serial events never wake; in green/normal they vector only when enabled.
// RL13: Voltage detector wakes/interrupts per enables; low voltage and watchdog reset.
//
// Local design decisions: the APB slave port and the address map.
`include "wrs_consts.vh"

module wrs_top (
	input  wire        ref_clk_in,
	input  wire        reset_in,
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [11:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output wire [31:0] prdata_out,
	output wire        pready_out,
	output wire        pslverr_out,
	input  wire        ext_reset_n_in,
	input  wire        low_voltage_reset_in,
	input  wire        pin_level_in,
	input  wire        watchdog_timeout_in,
	input  wire        watchdog_clear_instr_in,
	input  wire        sleep_instr_in,
	input  wire        global_irq_enable_in,
	input  wire        global_irq_disable_in,
	input  wire [1:0]  power_mode_in,
	input  wire        uart_tx_done_in,
	input  wire        uart_rx_full_in,
	input  wire        uart_rx_error_in,
	input  wire        voltage_detect_in,
	output wire        core_reset_out,
	output wire        wake_out,
	output wire        irq_vector_out,
	output wire        timeout_flag_out,
	output wire        power_down_flag_out,
	output wire        irq_out
);
	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	wire [2:0] pin_raw;
	wire [2:0] pin_sync;

	assign pin_raw = {pin_level_in, low_voltage_reset_in, ext_reset_n_in};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
			// Reset pin idles high, detector and port pin idle low
			wrs_sync3 #(
				.IDLE_LEVEL (gi == 0 ? 1'b1 : 1'b0)
			) u_sync (
				.ref_clk_in (ref_clk_in),
				.reset_in   (reset_in),
				.async_in   (pin_raw[gi]),
				.level_out  (pin_sync[gi])
			);
		end
	endgenerate

	wire ext_rst_n_s;
	wire lv_rst_s;
	wire pin_s;

	assign ext_rst_n_s = pin_sync[0];
	assign lv_rst_s    = pin_sync[1];
	assign pin_s       = pin_sync[2];

	function low_power;
		input [1:0] mode;
		begin
			low_power = (mode == `WRS_MODE_SLEEP) || (mode == `WRS_MODE_IDLE);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State
	reg                  ext_rst_n_d_r;
	reg                  lv_rst_d_r;
	reg                  pin_d_r;
	reg                  timeout_r;
	reg                  pdown_r;
	reg                  gie_r;
	reg                  core_reset_r;
	reg                  wake_r;
	reg                  vector_r;
	reg                  irq_r;
	reg [`WRS_CTL_W-1:0] ctrl_r;
	reg [`WRS_EVT_W-1:0] evt_r;
	reg [`WRS_EVT_W-1:0] mask_r;
	reg                  pready_r;
	reg                  pslverr_r;
	reg [31:0]           prdata_r;

	wire asleep;
	wire ext_rst_evt;
	wire lv_rst_evt;
	wire pin_chg_evt;
	wire wdog_evt;

	assign asleep      = low_power(power_mode_in);
	assign ext_rst_evt = ext_rst_n_d_r & ~ext_rst_n_s;
	assign lv_rst_evt  = lv_rst_s & ~lv_rst_d_r;
	assign pin_chg_evt = pin_s ^ pin_d_r;
	assign wdog_evt    = watchdog_timeout_in;

	wire wdc_instr;
	wire sleep_instr;
	wire gie_set;
	// A core held in reset fetches nothing, so its watchdog-clear, sleep and global-enable strobes are void
	assign wdc_instr   = watchdog_clear_instr_in & ~core_reset_r;
	assign sleep_instr = sleep_instr_in & ~core_reset_r;
	assign gie_set     = global_irq_enable_in & ~core_reset_r;

	////////////////////////////////////////////////////////////////////////////
	// Flag update
	reg timeout_nxt;
	reg pdown_nxt;

	always @* begin
		timeout_nxt = timeout_r;
		pdown_nxt   = pdown_r;
		if (ext_rst_evt) begin
			if (asleep) begin
				timeout_nxt = 1'b1; // [RL5]
				pdown_nxt   = 1'b0; // [RL5]
			end
			// Operating-mode pin reset leaves both flags alone [RL4]
		end else if (lv_rst_evt) begin
			timeout_nxt = 1'b1;
			pdown_nxt   = 1'b1;
		end else if (wdog_evt) begin
			timeout_nxt = 1'b0; // [RL6] [RL7]
			if (asleep) begin
				pdown_nxt = 1'b0; // [RL7]
			end
		end else if (pin_chg_evt && asleep) begin
			timeout_nxt = 1'b1; // [RL8]
			pdown_nxt   = 1'b0; // [RL8]
		end else if (wdc_instr) begin
			timeout_nxt = 1'b1; // [RL9]
			pdown_nxt   = 1'b1; // [RL9]
		end else if (sleep_instr) begin
			timeout_nxt = 1'b1; // [RL10]
			pdown_nxt   = 1'b0; // [RL10]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wake and vector decisions
	reg wake_nxt;
	reg vector_nxt;
	reg reset_nxt;

	always @* begin
		wake_nxt   = 1'b0;
		vector_nxt = 1'b0;
		// Held while the pin is low so the core stays parked [RL1]
		reset_nxt  = ~ext_rst_n_s | lv_rst_evt | wdog_evt; // [RL1] [RL13]
		if (asleep) begin
			// Serial events are ignored while asleep [RL12]
			if ((voltage_detect_in && ctrl_r[`WRS_CTL_VD_WAKE]) ||
				(pin_chg_evt) || lv_rst_evt || wdog_evt || ext_rst_evt) begin
				wake_nxt = 1'b1; // [RL13]
			end
			if (voltage_detect_in && ctrl_r[`WRS_CTL_VD_WAKE] &&
				ctrl_r[`WRS_CTL_VD_IE] && gie_r) begin
				vector_nxt = 1'b1; // [RL13]
			end
		end else if (gie_r && !reset_nxt) begin
			// Disabled globally: core simply runs on [RL12]
			if ((uart_tx_done_in  && ctrl_r[`WRS_CTL_UTX_IE]) ||
				(uart_rx_full_in  && ctrl_r[`WRS_CTL_URX_IE]) ||
				(uart_rx_error_in && ctrl_r[`WRS_CTL_UERR_IE]) ||
				(voltage_detect_in && ctrl_r[`WRS_CTL_VD_IE])) begin
				vector_nxt = 1'b1; // [RL12] [RL13]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state so read data comes from a flop
	wire       apb_access;
	wire       apb_done;
	wire       apb_wr;
	wire       addr_ok;
	wire [3:0] reg_sel;

	// One-hot register select; an unmapped address selects nothing
	// Full address compare, so no register shows up at an alias
	function [3:0] reg_decode;
		input [`WRS_ADDR_W-1:0] addr;
		begin
			reg_decode    = 4'h0;
			reg_decode[0] = (addr == `WRS_OFS_FLAGS);
			reg_decode[1] = (addr == `WRS_OFS_WAKE_CTRL);
			reg_decode[2] = (addr == `WRS_OFS_EVT_STATUS);
			reg_decode[3] = (addr == `WRS_OFS_EVT_MASK);
		end
	endfunction

	assign reg_sel    = reg_decode(paddr_in);
	assign apb_access = psel_in & penable_in;
	assign apb_done   = apb_access & pready_r;
	assign apb_wr     = apb_done & pwrite_in & ~pslverr_r;
	assign addr_ok    = |reg_sel;

	reg [31:0] rd_mux;

	always @* begin
		rd_mux = 32'h0000_0000;
		case (paddr_in)
			`WRS_OFS_FLAGS: begin
				rd_mux[`WRS_FLAG_TIMEOUT] = timeout_r; // [RL11]
				rd_mux[`WRS_FLAG_PDOWN]   = pdown_r;   // [RL11]
				rd_mux[`WRS_FLAG_GIE]     = gie_r;
			end
			`WRS_OFS_WAKE_CTRL:  rd_mux[`WRS_CTL_W-1:0] = ctrl_r;
			`WRS_OFS_EVT_STATUS: rd_mux[`WRS_EVT_W-1:0] = evt_r;
			`WRS_OFS_EVT_MASK:   rd_mux[`WRS_EVT_W-1:0] = mask_r;
			default:             rd_mux = 32'h0000_0000;
		endcase
	end

	wire [`WRS_EVT_W-1:0] evt_set;
	wire [`WRS_EVT_W-1:0] evt_clr;

	assign evt_set = {vector_nxt, wake_nxt, lv_rst_evt, wdog_evt, ext_rst_evt};
	assign evt_clr = (apb_wr && reg_sel[2]) ?
	                 pwdata_in[`WRS_EVT_W-1:0] : {`WRS_EVT_W{1'b0}};

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			ext_rst_n_d_r <= 1'b1;
			lv_rst_d_r    <= 1'b0;
			pin_d_r       <= 1'b0;
			// Only power-on lands here; pin and watchdog act via the flag update
			timeout_r     <= 1'b1; // [RL3]
			pdown_r       <= 1'b1; // [RL3]
			gie_r         <= 1'b0;
			core_reset_r  <= 1'b1; // [RL1]
			wake_r        <= 1'b0;
			vector_r      <= 1'b0;
			irq_r         <= 1'b0;
			ctrl_r        <= `WRS_CTL_RESET;
			evt_r         <= `WRS_EVT_RESET;
			mask_r        <= `WRS_MASK_RESET;
			pready_r      <= 1'b0;
			pslverr_r     <= 1'b0;
			prdata_r      <= 32'h0000_0000;
		end else begin
			ext_rst_n_d_r <= ext_rst_n_s;
			lv_rst_d_r    <= lv_rst_s;
			pin_d_r       <= pin_s;
			timeout_r     <= timeout_nxt;
			pdown_r       <= pdown_nxt;
			core_reset_r  <= reset_nxt;
			wake_r        <= wake_nxt;
			vector_r      <= vector_nxt;
			// A reset of the core also drops global enable
			if (reset_nxt || global_irq_disable_in) begin
				gie_r <= 1'b0;
			end else if (gie_set) begin
				gie_r <= 1'b1;
			end
			// New event beats a same-cycle clear
			evt_r <= (evt_r & ~evt_clr) | evt_set;
			irq_r <= |(evt_r & mask_r);
			if (apb_wr && reg_sel[1]) begin
				ctrl_r <= pwdata_in[`WRS_CTL_W-1:0];
			end
			if (apb_wr && reg_sel[3]) begin
				mask_r <= pwdata_in[`WRS_EVT_W-1:0];
			end
			pready_r  <= apb_access & ~pready_r;
			pslverr_r <= apb_access & ~pready_r & ~addr_ok;
			if (apb_access && !pready_r) begin
				prdata_r <= addr_ok ? rd_mux : 32'h0000_0000;
			end
		end
	end

	assign prdata_out          = prdata_r;
	assign pready_out          = pready_r;
	assign pslverr_out         = pslverr_r;
	assign core_reset_out      = core_reset_r;
	assign wake_out            = wake_r;
	assign irq_vector_out      = vector_r;
	assign timeout_flag_out    = timeout_r;
	assign power_down_flag_out = pdown_r;
	assign irq_out             = irq_r;
endmodule // wrs_top

// ---- verification/wrs_checker.sv ----
// Port-level assertions for the wake and reset status logic
module wrs_checker (
	input logic       ref_clk_in,
	input logic       reset_in,
	input logic       psel_in,
	input logic       penable_in,
	input logic       pready_out,
	input logic       pslverr_out,
	input logic       ext_reset_n_in,
	input logic       watchdog_timeout_in,
	input logic       watchdog_clear_instr_in,
	input logic       sleep_instr_in,
	input logic [1:0] power_mode_in,
	input logic       uart_tx_done_in,
	input logic       uart_rx_full_in,
	input logic       uart_rx_error_in,
	input logic       voltage_detect_in,
	input logic       core_reset_out,
	input logic       wake_out,
	input logic       irq_vector_out,
	input logic       timeout_flag_out,
	input logic       power_down_flag_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	wire [1:0] tp = {timeout_flag_out, power_down_flag_out};
	wire       ua = uart_tx_done_in | uart_rx_full_in | uart_rx_error_in;
	wire       op = power_mode_in[1] & ~core_reset_out;
	////////////////////////////////////////
	sequence s_setup; psel_in && !penable_in; endsequence
	sequence s_wait; psel_in && penable_in && !pready_out; endsequence
	a_apb_one_wait: assert property (s_setup ##1 s_wait |=> pready_out)
		else $error("ready late");
	a_err_ready: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	a_por_flags: assert property ($fell(reset_in) |-> tp == 2'b11)
		else $error("flags after power-on");
	a_wdog_run: assert property (watchdog_timeout_in && op && ext_reset_n_in
		|=> core_reset_out && tp == {1'b0, $past(power_down_flag_out)})
		else $error("watchdog in run mode");
	a_wdog_sleep: assert property (watchdog_timeout_in && power_mode_in == 2'h0
		&& !core_reset_out |=> tp == 2'b00 && wake_out)
		else $error("watchdog wake");
	a_wdc_flags: assert property (watchdog_clear_instr_in && !watchdog_timeout_in && op
		|=> tp == 2'b11)
		else $error("watchdog clear flags");
	a_sleep_flags: assert property (sleep_instr_in && !watchdog_clear_instr_in
		&& !watchdog_timeout_in && op |=> tp == 2'b10)
		else $error("sleep flags");
	a_uart_quiet: assert property (ua && !power_mode_in[1] && !voltage_detect_in
		|=> !irq_vector_out)
		else $error("serial event acted in sleep");
	a_pin_reset: assert property (!ext_reset_n_in [*8] |=> core_reset_out)
		else $error("pin low without reset");
endmodule // wrs_checker

bind wrs_top wrs_checker i_wrs_checker (.*);

// ---- verification/wrs_partner.sv ----
// Reset pin driver of the surrounding system
module wrs_partner (
	input  logic ref_clk_in,
	input  logic go_in,
	output logic ext_reset_n_out,
	output logic busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r = 4'h0;
	// Pin idles high, drops for ten cycles, then returns high
	assign ext_reset_n_out = (cnt_r == 4'h0);
	assign busy_out = |cnt_r;
	always @(posedge ref_clk_in) begin
		if (go_in && cnt_r == 4'h0)
			cnt_r <= 4'ha;
		else if (|cnt_r)
			cnt_r <= cnt_r - 4'h1;
	end
endmodule // wrs_partner

// ---- verification/wrs_top_tb.sv ----
// Self-checking bench for the wake and reset status logic
module wrs_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [8:0] WD = 9'h001, WDC = 9'h002, SLP = 9'h004, GEN = 9'h008;
	localparam [8:0] GDIS = 9'h010, UTX = 9'h020, URX = 9'h040, UERR = 9'h080;
	localparam [8:0] VD = 9'h100;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic        low_voltage_reset = 1'b0, pin = 1'b0, go = 1'b0, err, crd = 1'b0;
	logic [8:0]  evt = 9'h000;
	logic [1:0]  mode = 2'h3;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdat = 32'h0, rdat;
	wire  [31:0] prdata;
	wire         pready, pslverr, ext_rst_n, crst, wake, vec, tf, pf, irq, busy;
	int          bad_count = 0, cmp_count = 0, wk = 0, vc = 0, cyc = 0, rc = 0;
	////////////////////////////////////////
	wrs_top i_wrs_top (.ref_clk_in(clk), .reset_in(rst), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdat),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.ext_reset_n_in(ext_rst_n), .low_voltage_reset_in(low_voltage_reset), .pin_level_in(pin),
		.watchdog_timeout_in(evt[0]), .watchdog_clear_instr_in(evt[1]),
		.sleep_instr_in(evt[2]), .global_irq_enable_in(evt[3]),
		.global_irq_disable_in(evt[4]), .power_mode_in(mode),
		.uart_tx_done_in(evt[5]), .uart_rx_full_in(evt[6]),
		.uart_rx_error_in(evt[7]), .voltage_detect_in(evt[8]),
		.core_reset_out(crst), .wake_out(wake), .irq_vector_out(vec),
		.timeout_flag_out(tf), .power_down_flag_out(pf), .irq_out(irq));
	wrs_partner i_wrs_partner (.ref_clk_in(clk), .go_in(go),
		.ext_reset_n_out(ext_rst_n), .busy_out(busy));
	always #2 clk = ~clk;
	always @(posedge clk) begin
		wk += (wake === 1'b1);
		vc += (vec === 1'b1);
		// Core reset counted once per rise, however long it stands
		rc += (crst === 1'b1 && crd !== 1'b1);
		crd = crst;
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			finish_test;
		end
	end
	////////////////////////////////////////
	task chk(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			bad_count++;
			$display("CHECK FAILED at %0t: exp %h got %h", $time, e, g);
		end
	endtask
	// Ready, data and error are taken at the rising edge that sees ready high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task ev(input logic [8:0] v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= 9'h000;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask
	task ext_pulse;
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(negedge clk);
		while (busy === 1'b1)
			@(negedge clk);
		repeat (8) @(negedge clk);
	endtask
	task set_mode(input logic [1:0] m);
		@(posedge clk);
		mode <= m;
	endtask
	task finish_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(2'b11, {tf, pf});
		apb(1'b0, 12'h000, 32'h0);
		chk(32'h3, rdat);
		apb(1'b0, 12'h010, 32'h0);
		chk(1'b1, err);
		apb(1'b1, 12'h004, 32'hffffffff);
		apb(1'b0, 12'h004, 32'h0);
		chk(32'h1f, rdat);
		ev(WD);
		chk(2'b01, {tf, pf});
		apb(1'b1, 12'h00c, 32'h2);
		chk(1'b1, irq);
		apb(1'b1, 12'h008, 32'h1f);
		chk(1'b0, irq);
		ev(WDC);
		chk(2'b11, {tf, pf});
		ev(SLP);
		chk(2'b10, {tf, pf});
		set_mode(2'h0);
		ev(WD);
		chk(2'b00, {tf, pf});
		ext_pulse;
		chk(2'b10, {tf, pf});
		ev(WD);
		@(posedge clk);
		pin <= ~pin;
		repeat (10) @(negedge clk);
		chk(2'b10, {tf, pf});
		chk(4, wk);
		set_mode(2'h3);
		ev(WD);
		ext_pulse;
		chk(2'b00, {tf, pf});
		@(posedge clk);
		low_voltage_reset <= 1'b1;
		repeat (8) @(posedge clk);
		low_voltage_reset <= 1'b0;
		repeat (8) @(negedge clk);
		chk(2'b11, {tf, pf});
		chk(8, rc);
		apb(1'b0, 12'h008, 32'h0);
		chk(32'hf, rdat);
		ev(GEN);
		ev(UTX);
		ev(GDIS);
		ev(URX);
		chk(1, vc);
		set_mode(2'h0);
		ev(GEN);
		ev(UERR);
		chk(4, wk);
		ev(VD);
		chk(5, wk);
		chk(2, vc);
		set_mode(2'h1);
		apb(1'b1, 12'h004, 32'h10);
		ev(VD);
		chk(5, wk);
		apb(1'b1, 12'h004, 32'h08);
		ev(VD);
		chk(6, wk);
		chk(2, vc);
		finish_test;
	end
endmodule // wrs_top_tb
